// ==== rtl/bit_test_skip_when_one.sv ====
// Summary of operation
// - opcode 1010 tests bit b of file f; skips next instruction when bit is one.
// - taken skip discards prefetched word, runs no_operation; two cycles total.
// - access-select 0 uses common access bank, ignoring bank_select_reg.
// - access-select 1 takes operand bank from bank_select_reg.
// - skipped two-word instruction gives three cycles, both words replaced.
`timescale 1ns/1ps
module bit_test_skip_when_one
    import bit_skip_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // instruction stream
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic next_is_two_word,
    input wire logic [BANK_W-1:0] bank_select_reg,
    // data memory
    output mem_req_s mem_req,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    // pipeline control
    output logic [1:0] phase,
    output logic busy,
    output logic discard_fetch,
    output logic skip_taken,
    output logic status_we
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    phase_e ph_r, ph_nxt;
    logic active_r, active_nxt;
    logic [2:0] bit_r, bit_nxt;
    mem_req_s req_r, req_nxt;
    logic [1:0] skip_r, skip_nxt;
    logic taken_r, taken_nxt;
    logic two_r, two_nxt;
    logic hit;

    assign hit = instr_valid && instr_word[OPC_HI:OPC_LO] == OPC_SKIP_SET;

    always_comb
    begin
        ph_nxt = ph_r;
        active_nxt = active_r;
        bit_nxt = bit_r;
        req_nxt = req_r;
        skip_nxt = skip_r;
        taken_nxt = 1'b0;
        two_nxt = two_r;
        unique case (ph_r)
            PH_DECODE:
            begin
                ph_nxt = PH_READ;
                if (skip_r != 2'h0)
                begin
                    // no_operation cycle in place of skipped word
                    active_nxt = 1'b0;
                end
                else
                begin
                    active_nxt = hit;
                    bit_nxt = instr_word[BIT_HI:BIT_LO];
                    req_nxt.addr = instr_word[FILE_HI:FILE_LO];
                    req_nxt.access_common = instr_word[ACC_POS] == ACC_COMMON;
                    two_nxt = next_is_two_word;
                    req_nxt.bank = (instr_word[ACC_POS] == ACC_COMMON) ? COMMON_BANK
                                   : bank_select_reg;
                end
            end
            PH_READ:
                ph_nxt = PH_PROCESS;
            PH_PROCESS:
            begin
                ph_nxt = PH_WRITE;
                if (active_r && mem_rdata[bit_r])
                begin
                    taken_nxt = 1'b1;
                    skip_nxt = two_r ? SKIP_TWO : SKIP_ONE;
                end
            end
            PH_WRITE:
            begin
                ph_nxt = PH_DECODE;
                active_nxt = 1'b0;
                if (skip_r != 2'h0 && !taken_r)
                    skip_nxt = skip_r - 2'h1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ph_r <= PH_DECODE;
            active_r <= 1'b0;
            bit_r <= 3'h0;
            req_r <= '0;
            skip_r <= PHASE_RESET;
            taken_r <= 1'b0;
            two_r <= 1'b0;
        end
        else
        begin
            ph_r <= ph_nxt;
            active_r <= active_nxt;
            bit_r <= bit_nxt;
            req_r <= req_nxt;
            skip_r <= skip_nxt;
            taken_r <= taken_nxt;
            two_r <= two_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign phase = ph_r;
    assign mem_req = req_r;
    assign mem_rd = active_r && ph_r == PH_READ;
    assign busy = skip_r != 2'h0;
    assign discard_fetch = skip_r != 2'h0;
    assign skip_taken = taken_r;
    assign status_we = 1'b0;

    // ------------------------------------------------------------
    // no_operation run length, read by checks only
    // ------------------------------------------------------------
    logic [3:0] nop_len_r, nop_len_nxt;

    always_comb
    begin
        nop_len_nxt = discard_fetch ? 4'(nop_len_r + 4'h1) : 4'h0;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            nop_len_r <= 4'h0;
        else
            nop_len_r <= nop_len_nxt;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // bit found set in q3
    sequence s_set_hit;
        ph_r == PH_PROCESS && active_r && mem_rdata[bit_r];
    endsequence

    // instruction accepted in q1
    sequence s_decode_take;
        ph_r == PH_DECODE && skip_r == 2'h0 && hit;
    endsequence

    // one full instruction cycle
    sequence s_q_cycle;
        ph_r == PH_DECODE ##1 ph_r == PH_READ ##1 ph_r == PH_PROCESS ##1 ph_r == PH_WRITE;
    endsequence

    // read in q2, evaluate in q3
    sequence s_read_eval;
        mem_rd ##1 (ph_r == PH_PROCESS && active_r);
    endsequence

    a_phase_order: assert property (ph_r == PH_WRITE |=> ph_r == PH_DECODE)
        else $error("phase order broken");
    a_phase_walk: assert property (ph_r == PH_DECODE |-> s_q_cycle)
        else $error("phase walk broken");
    a_read_phase: assert property (mem_rd |-> ph_r == PH_READ)
        else $error("read outside phase two");
    a_read_eval: assert property (mem_rd |-> s_read_eval)
        else $error("read not followed by evaluate");
    a_no_flags: assert property (!status_we)
        else $error("status written");
    a_decode_take: assert property (s_decode_take |=> active_r && mem_rd)
        else $error("instruction not taken");
    a_skip_refused: assert property (ph_r == PH_DECODE && skip_r != 2'h0 |=> !active_r)
        else $error("word decoded during skip");
    a_skip_one: assert property ((s_set_hit and !two_r)
                                 |=> ##3 discard_fetch ##4 !discard_fetch)
        else $error("single skip length wrong");
    a_skip_two: assert property ((s_set_hit and two_r)
                                 |=> ##7 discard_fetch ##4 !discard_fetch)
        else $error("double skip length wrong");
    a_taken_pulse: assert property (skip_taken |=> !skip_taken)
        else $error("skip flag longer than one cycle");
    a_taken_source: assert property (skip_taken |-> $past(mem_rd, 2))
        else $error("skip without a read");
    a_nop_no_read: assert property (discard_fetch |-> !mem_rd)
        else $error("read during no_operation");
    a_nop_len_one: assert property (!discard_fetch && nop_len_r != 4'h0 && !two_r
                                    |-> nop_len_r == NOP_LEN_ONE)
        else $error("single skip run length wrong");
    a_nop_len_two: assert property (!discard_fetch && nop_len_r != 4'h0 && two_r
                                    |-> nop_len_r == NOP_LEN_TWO)
        else $error("double skip run length wrong");
    a_no_skip: assert property (ph_r == PH_PROCESS && !(active_r && mem_rdata[bit_r])
                                && skip_r == 2'h0 |=> ##1 !discard_fetch)
        else $error("skip without set bit");
    a_common_bank: assert property (ph_r == PH_DECODE && skip_r == 2'h0 && hit
                                    && !instr_word[ACC_POS] |=> mem_req.bank == COMMON_BANK)
        else $error("common bank not used");
    a_bsr_bank: assert property (ph_r == PH_DECODE && skip_r == 2'h0 && hit
                                 && instr_word[ACC_POS]
                                 |=> mem_req.bank == $past(bank_select_reg))
        else $error("bank select not used");

endmodule

// ==== rtl/bit_skip_pkg.sv ====
package bit_skip_pkg;

    // ------------------------------------------------------------
    // instruction encoding
    // ------------------------------------------------------------
    localparam logic [3:0] OPC_SKIP_SET = 4'hA;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 12;
    localparam int BIT_HI = 11;
    localparam int BIT_LO = 9;
    localparam int ACC_POS = 8;
    localparam int FILE_HI = 7;
    localparam int FILE_LO = 0;
    localparam logic ACC_COMMON = 1'h0;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int BANK_W = 4;
    localparam logic [BANK_W-1:0] COMMON_BANK = 4'h0;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_TWO = 2'h2;
    localparam logic [3:0] NOP_LEN_ONE = 4'h5;
    localparam logic [3:0] NOP_LEN_TWO = 4'h9;

    typedef enum logic [1:0]
    {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE = 2'b11
    } phase_e;

    typedef struct packed
    {
        logic [BANK_W-1:0] bank;
        logic [7:0] addr;
        logic access_common;
    } mem_req_s;

endpackage

// ==== testbench/skip_mem_model.sv ====
`timescale 1ns/1ps
module skip_mem_model
    import bit_skip_pkg::*;
(
    // request
    input wire logic clk,
    input wire mem_req_s mem_req,
    input wire logic mem_rd,
    // data
    output logic [7:0] mem_rdata
);
    // byte stands one clock, then toggles
    always_ff @(posedge clk)
    begin
        if (mem_rd)
            mem_rdata <= mem_req.addr ^ {mem_req.bank, mem_req.bank} ^ 8'h5A;
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

// ==== testbench/bit_test_skip_when_one_tb.sv ====
`timescale 1ns/1ps
module bit_test_skip_when_one_tb
    import bit_skip_pkg::*;
;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic vld = 1'h0;
    logic two_w = 1'h0;
    logic [15:0] word = 16'h0000;
    logic [3:0] bsel = 4'h0;
    mem_req_s mem_req;
    logic mem_rd, busy, discard_fetch, skip_taken, status_we;
    logic [1:0] phase;
    logic [7:0] mem_rdata;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    initial forever #12.5 clk = ~clk;
    bit_test_skip_when_one u_bit_test_skip_when_one (.clk(clk), .reset_n(reset_n),
        .instr_word(word), .instr_valid(vld), .next_is_two_word(two_w),
        .bank_select_reg(bsel), .mem_req(mem_req), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .phase(phase), .busy(busy), .discard_fetch(discard_fetch),
        .skip_taken(skip_taken), .status_we(status_we));
    skip_mem_model u_skip_mem_model (.clk(clk), .mem_req(mem_req), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));
    // ----
    // checks
    // ----
    task end_sim;
    begin
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk_bit(input logic got, input logic exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task chk_req(input mem_req_s got, input mem_req_s exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task chk_phase(input logic [1:0] got, input logic [1:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    function automatic mem_req_s exp_req(input logic [15:0] w, input logic [3:0] b);
        return '{w[ACC_POS] ? b : COMMON_BANK, w[7:0], !w[ACC_POS]};
    endfunction
    task run(input logic [15:0] w, input logic v, input logic t, input logic [3:0] b);
        logic op;
        logic sk;
        mem_req_s er;
        logic [7:0] d;
    begin
        op = v && w[15:12] == OPC_SKIP_SET;
        er = exp_req(w, b);
        d = er.addr ^ {er.bank, er.bank} ^ 8'h5A;
        sk = op && d[w[11:9]];
        word <= w;
        vld <= v;
        two_w <= t;
        bsel <= b;
        @(posedge clk);
        word <= ~w;
        bsel <= ~b;
        #1 chk_bit(mem_rd, op);
        chk_phase(phase, PH_READ);
        if (op)
            chk_req(mem_req, er);
        repeat (2) @(posedge clk);
        #1 chk_bit(skip_taken, sk);
        chk_bit(status_we, 1'h0);
        chk_bit(discard_fetch, sk);
        chk_bit(busy, sk);
        chk_phase(phase, PH_WRITE);
        @(posedge clk);
        if (sk)
        begin
            word <= {OPC_SKIP_SET, 12'h1FF};
            vld <= 1'h1;
            repeat (t ? 7 : 3) @(posedge clk);
            #1 chk_bit(discard_fetch, 1'h1);
            chk_bit(mem_rd, 1'h0);
            chk_bit(busy, 1'h1);
            @(posedge clk);
            #1 chk_bit(discard_fetch, 1'h0);
            chk_bit(busy, 1'h0);
        end
    end
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim;
        end
    end
    initial
    begin
        logic [15:0] w;
        void'($urandom(30338));
        repeat (5) @(posedge clk);
        reset_n <= 1'h1;
        run(16'hA200, 1'h1, 1'h1, 4'hF);
        run(16'hA000, 1'h1, 1'h0, 4'hF);
        run(16'hA100, 1'h1, 1'h0, 4'hF);
        run(16'hB100, 1'h1, 1'h0, 4'hF);
        repeat (300)
        begin
            w = 16'($urandom);
            if ($urandom % 4 != 0)
                w[15:12] = OPC_SKIP_SET;
            run(w, 1'($urandom % 8 != 0), 1'($urandom), 4'($urandom));
        end
        end_sim;
    end
endmodule
